// File: inc/amb_pkg.sv
package amb_pkg;
	localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
	localparam logic [7:0] PHASE_ALL = 8'hFF;
	localparam logic [7:0] SEL_VOUT = 8'h7A;
	localparam logic [7:0] SEL_IOUT = 8'h7B;
	localparam logic [7:0] SEL_INPUT = 8'h7C;
	localparam logic [7:0] SEL_TEMP = 8'h7D;
	localparam logic [7:0] SEL_COMMS = 8'h7E;
	localparam logic [7:0] WMASK_VOUT = 8'hFC;
	localparam logic [7:0] WMASK_IOUT = 8'hB0;
	localparam logic [7:0] WMASK_INPUT = 8'h08;
	localparam logic [7:0] WMASK_TEMP = 8'hC0;
	localparam logic [7:0] WMASK_COMMS = 8'hF2;
	localparam int NUM_CAT = 5;
	localparam int CAT_VOUT = 0;
	localparam int CAT_IOUT = 1;
	localparam int CAT_INPUT = 2;
	localparam int CAT_TEMP = 3;
	localparam int CAT_COMMS = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int POS_OUT_OVERVOLT_FAULT = 7;
	localparam int POS_OUT_OVERVOLT_WARN = 6;
	localparam int POS_OUT_UNDERVOLT_WARN = 5;
	localparam int POS_OUT_UNDERVOLT_FAULT = 4;
	localparam int POS_OUT_RANGE_VIOLATION = 3;
	localparam int POS_TURN_ON_TIMEOUT = 2;
	localparam int POS_OVERCURRENT_FAULT = 7;
	localparam int POS_OVERCURRENT_WARN = 5;
	localparam int POS_UNDERCURRENT_FAULT = 4;
	localparam int POS_LOW_INPUT_VOLTAGE = 3;
	localparam int POS_OVERTEMP_FAULT = 7;
	localparam int POS_OVERTEMP_WARN = 6;
endpackage

// File: src/amb_alert_mask_bank.sv
`timescale 1ns/10ps
module amb_alert_mask_bank
	import amb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] nvmVout,
	input wire logic [7:0] nvmIout,
	input wire logic [7:0] nvmInput,
	input wire logic [7:0] nvmTemp,
	input wire logic [7:0] nvmComms,
	input wire logic nvmLoad,
	input wire logic [7:0] phase,
	input wire logic [7:0] cmdCode,
	input wire logic wordWrite,
	input wire logic [7:0] wrLowByte,
	input wire logic [7:0] wrHighByte,
	input wire logic readCall,
	input wire logic [7:0] rdStatusCmd,
	input wire logic [7:0] statusVout,
	input wire logic [7:0] statusIout,
	input wire logic [7:0] statusInput,
	input wire logic [7:0] statusTemp,
	input wire logic [7:0] statusComms,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic badData,
	output logic [7:0] backupVout,
	output logic [7:0] backupIout,
	output logic [7:0] backupInput,
	output logic [7:0] backupTemp,
	output logic [7:0] backupComms,
	output logic [7:0] statusOutVout,
	output logic alert
);
	logic [7:0] mask_q [NUM_CAT];
	logic [7:0] nvmVal [NUM_CAT];
	logic [7:0] statusVal [NUM_CAT];
	logic [7:0] wmask [NUM_CAT];
	logic [NUM_CAT-1:0] wrHit;
	logic [NUM_CAT-1:0] rdHit;
	logic [NUM_CAT-1:0] catAlert;
	logic accessOk;
	logic [7:0] rdMux;
	logic alert_d;
	logic alert_q;
	logic wrAny;
	logic rdAny;

	assign nvmVal[CAT_VOUT] = nvmVout;
	assign nvmVal[CAT_IOUT] = nvmIout;
	assign nvmVal[CAT_INPUT] = nvmInput;
	assign nvmVal[CAT_TEMP] = nvmTemp;
	assign nvmVal[CAT_COMMS] = nvmComms;
	assign statusVal[CAT_VOUT] = statusVout;
	assign statusVal[CAT_IOUT] = statusIout;
	assign statusVal[CAT_INPUT] = statusInput;
	assign statusVal[CAT_TEMP] = statusTemp;
	assign statusVal[CAT_COMMS] = statusComms;
	assign wmask[CAT_VOUT] = WMASK_VOUT;
	assign wmask[CAT_IOUT] = WMASK_IOUT;
	assign wmask[CAT_INPUT] = WMASK_INPUT;
	assign wmask[CAT_TEMP] = WMASK_TEMP;
	assign wmask[CAT_COMMS] = WMASK_COMMS;

	// accesses only count at the shared command and the all-phase selection
	assign accessOk = (cmdCode == CMD_ALERT_MASK) && (phase == PHASE_ALL);

	// sub-command decode for writes (low byte) and reads (block byte)
	always_comb begin
		wrHit = '0;
		rdHit = '0;
		case (wrLowByte)
			SEL_VOUT: wrHit[CAT_VOUT] = 1'b1;
			SEL_IOUT: wrHit[CAT_IOUT] = 1'b1;
			SEL_INPUT: wrHit[CAT_INPUT] = 1'b1;
			SEL_TEMP: wrHit[CAT_TEMP] = 1'b1;
			SEL_COMMS: wrHit[CAT_COMMS] = 1'b1;
			default: wrHit = '0;
		endcase
		case (rdStatusCmd)
			SEL_VOUT: rdHit[CAT_VOUT] = 1'b1;
			SEL_IOUT: rdHit[CAT_IOUT] = 1'b1;
			SEL_INPUT: rdHit[CAT_INPUT] = 1'b1;
			SEL_TEMP: rdHit[CAT_TEMP] = 1'b1;
			SEL_COMMS: rdHit[CAT_COMMS] = 1'b1;
			default: rdHit = '0;
		endcase
	end

	assign wrAny = |wrHit;
	assign rdAny = |rdHit;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CAT; gi++) begin : g_cat
			// nvm value at reset or reload, host writes take effect next edge
			always_ff @(posedge clock) begin
				if (!rst_b || nvmLoad) begin
					mask_q[gi] <= nvmVal[gi] & wmask[gi];
				end else if (wordWrite && accessOk && wrHit[gi]) begin
					mask_q[gi] <= wrHighByte & wmask[gi];
				end
			end
			// per-category alert from unmasked set status bits only
			assign catAlert[gi] = |(statusVal[gi] & ~mask_q[gi]);
		end
	endgenerate

	always_comb begin
		rdMux = ZERO_BYTE;
		for (int i = 0; i < NUM_CAT; i++) begin
			if (rdHit[i]) begin
				rdMux = mask_q[i];
			end
		end
	end

	// one-byte block answer, one cycle after the process call
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdData <= ZERO_BYTE;
			rdValid <= 1'b0;
		end else begin
			rdValid <= readCall && accessOk && rdAny;
			rdData <= (readCall && accessOk && rdAny) ? rdMux : rdData;
		end
	end

	// unsupported data pulse for unknown sub-command or wrong phase
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			badData <= 1'b0;
		end else begin
			badData <= (cmdCode == CMD_ALERT_MASK) &&
				((wordWrite && !(accessOk && wrAny)) ||
				(readCall && !(accessOk && rdAny)));
		end
	end

	assign alert_d = |catAlert;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_d;
		end
	end
	assign alert = alert_q;

	// VOUT status passes through untouched by the mask
	assign statusOutVout = statusVout;
	assign backupVout = mask_q[CAT_VOUT];
	assign backupIout = mask_q[CAT_IOUT];
	assign backupInput = mask_q[CAT_INPUT];
	assign backupTemp = mask_q[CAT_TEMP];
	assign backupComms = mask_q[CAT_COMMS];

	// named mask fields, cross-check of the alert path bit by bit
	logic maskOutOvervoltFault;
	logic maskOutOvervoltWarn;
	logic maskOutUndervoltWarn;
	logic maskOutUndervoltFault;
	logic maskOutRangeViolation;
	logic maskTurnOnTimeout;
	logic maskOvercurrentFault;
	logic maskOvercurrentWarn;
	logic maskUndercurrentFault;
	logic maskLowInputVoltage;
	logic maskOvertempFault;
	logic maskOvertempWarn;
	logic fieldAlert;

	assign maskOutOvervoltFault = mask_q[CAT_VOUT][POS_OUT_OVERVOLT_FAULT];
	assign maskOutOvervoltWarn = mask_q[CAT_VOUT][POS_OUT_OVERVOLT_WARN];
	assign maskOutUndervoltWarn = mask_q[CAT_VOUT][POS_OUT_UNDERVOLT_WARN];
	assign maskOutUndervoltFault = mask_q[CAT_VOUT][POS_OUT_UNDERVOLT_FAULT];
	assign maskOutRangeViolation = mask_q[CAT_VOUT][POS_OUT_RANGE_VIOLATION];
	assign maskTurnOnTimeout = mask_q[CAT_VOUT][POS_TURN_ON_TIMEOUT];
	assign maskOvercurrentFault = mask_q[CAT_IOUT][POS_OVERCURRENT_FAULT];
	assign maskOvercurrentWarn = mask_q[CAT_IOUT][POS_OVERCURRENT_WARN];
	assign maskUndercurrentFault = mask_q[CAT_IOUT][POS_UNDERCURRENT_FAULT];
	assign maskLowInputVoltage = mask_q[CAT_INPUT][POS_LOW_INPUT_VOLTAGE];
	assign maskOvertempFault = mask_q[CAT_TEMP][POS_OVERTEMP_FAULT];
	assign maskOvertempWarn = mask_q[CAT_TEMP][POS_OVERTEMP_WARN];

	assign fieldAlert = (statusVout[POS_OUT_OVERVOLT_FAULT] && !maskOutOvervoltFault) ||
		(statusVout[POS_OUT_OVERVOLT_WARN] && !maskOutOvervoltWarn) ||
		(statusVout[POS_OUT_UNDERVOLT_WARN] && !maskOutUndervoltWarn) ||
		(statusVout[POS_OUT_UNDERVOLT_FAULT] && !maskOutUndervoltFault) ||
		(statusVout[POS_OUT_RANGE_VIOLATION] && !maskOutRangeViolation) ||
		(statusVout[POS_TURN_ON_TIMEOUT] && !maskTurnOnTimeout) ||
		(statusIout[POS_OVERCURRENT_FAULT] && !maskOvercurrentFault) ||
		(statusIout[POS_OVERCURRENT_WARN] && !maskOvercurrentWarn) ||
		(statusIout[POS_UNDERCURRENT_FAULT] && !maskUndercurrentFault) ||
		(statusInput[POS_LOW_INPUT_VOLTAGE] && !maskLowInputVoltage) ||
		(statusTemp[POS_OVERTEMP_FAULT] && !maskOvertempFault) ||
		(statusTemp[POS_OVERTEMP_WARN] && !maskOvertempWarn);


	// checks on the mask contract
	chk_vout_low_zero: assert property (@(posedge clock) disable iff (!rst_b)
		backupVout[1:0] == 2'b00) else $error("vout mask low bits not zero");
	chk_iout_fixed_zero: assert property (@(posedge clock) disable iff (!rst_b)
		(backupIout & ~WMASK_IOUT) == ZERO_BYTE) else $error("iout reserved bits set");
	chk_input_only_b3: assert property (@(posedge clock) disable iff (!rst_b)
		(backupInput & ~WMASK_INPUT) == ZERO_BYTE) else $error("input reserved bits set");
	chk_temp_low_zero: assert property (@(posedge clock) disable iff (!rst_b)
		backupTemp[5:0] == 6'h00) else $error("temp low bits set");
	chk_reset_loads_nvm: assert property (@(posedge clock)
		!rst_b |=> backupVout == ($past(nvmVout) & WMASK_VOUT) &&
		backupTemp == ($past(nvmTemp) & WMASK_TEMP)) else $error("reset load lost");
	chk_reset_outputs_low: assert property (@(posedge clock)
		!rst_b |=> !alert && !rdValid && !badData) else $error("outputs high after reset");
	chk_reload_nvm: assert property (@(posedge clock) disable iff (!rst_b)
		nvmLoad |=> backupIout == ($past(nvmIout) & WMASK_IOUT) &&
		backupInput == ($past(nvmInput) & WMASK_INPUT) &&
		backupComms == ($past(nvmComms) & WMASK_COMMS)) else $error("reload lost");
	chk_vout_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrLowByte == SEL_VOUT && !nvmLoad
		|=> backupVout == ($past(wrHighByte) & WMASK_VOUT)) else $error("vout write lost");
	chk_iout_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrLowByte == SEL_IOUT && !nvmLoad
		|=> backupIout == ($past(wrHighByte) & WMASK_IOUT)) else $error("iout write lost");
	chk_input_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrLowByte == SEL_INPUT && !nvmLoad
		|=> backupInput == ($past(wrHighByte) & WMASK_INPUT)) else $error("input write lost");
	chk_temp_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrLowByte == SEL_TEMP && !nvmLoad
		|=> backupTemp == ($past(wrHighByte) & WMASK_TEMP)) else $error("temp write lost");
	chk_comms_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrLowByte == SEL_COMMS && !nvmLoad
		|=> backupComms == ($past(wrHighByte) & WMASK_COMMS)) else $error("comms write lost");
	chk_phase_guard: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && phase != PHASE_ALL && !nvmLoad
		|=> $stable(backupVout) && $stable(backupTemp)) else $error("write outside phase");
	chk_bad_sub_nochange: assert property (@(posedge clock) disable iff (!rst_b)
		cmdCode == CMD_ALERT_MASK && wordWrite && !wrAny && !nvmLoad
		|=> $stable(backupIout) && $stable(backupInput) && badData)
		else $error("unknown sub-command changed mask");
	chk_bad_phase_flag: assert property (@(posedge clock) disable iff (!rst_b)
		cmdCode == CMD_ALERT_MASK && phase != PHASE_ALL && (wordWrite || readCall)
		|=> badData && !rdValid) else $error("wrong phase not flagged");
	chk_bad_sub_read: assert property (@(posedge clock) disable iff (!rst_b)
		cmdCode == CMD_ALERT_MASK && readCall && !rdAny
		|=> badData && !rdValid) else $error("unknown read sub-command answered");
	chk_other_cmd_ignored: assert property (@(posedge clock) disable iff (!rst_b)
		cmdCode != CMD_ALERT_MASK && (wordWrite || readCall) && !nvmLoad
		|=> !badData && !rdValid && $stable(backupIout) && $stable(backupVout))
		else $error("other command touched masks");
	chk_good_write_quiet: assert property (@(posedge clock) disable iff (!rst_b)
		wordWrite && accessOk && wrAny && !readCall |=> !badData)
		else $error("accepted write flagged");
	chk_valid_needs_call: assert property (@(posedge clock) disable iff (!rst_b)
		rdValid |-> $past(readCall) && $past(cmdCode) == CMD_ALERT_MASK)
		else $error("read answer without call");
	chk_bad_needs_access: assert property (@(posedge clock) disable iff (!rst_b)
		badData |-> $past(cmdCode) == CMD_ALERT_MASK && ($past(wordWrite) || $past(readCall)))
		else $error("unsupported flag without access");
	chk_rddata_holds: assert property (@(posedge clock) disable iff (!rst_b)
		!rdValid && $past(rst_b) |-> $stable(rdData)) else $error("read data moved alone");
	chk_read_answer: assert property (@(posedge clock) disable iff (!rst_b)
		readCall && accessOk && rdStatusCmd == SEL_TEMP && !nvmLoad
		|=> rdValid && rdData == $past(backupTemp)) else $error("read answer wrong");
	chk_read_vout: assert property (@(posedge clock) disable iff (!rst_b)
		readCall && accessOk && rdStatusCmd == SEL_VOUT
		|=> rdValid && rdData == $past(backupVout)) else $error("vout read wrong");
	chk_read_iout: assert property (@(posedge clock) disable iff (!rst_b)
		readCall && accessOk && rdStatusCmd == SEL_IOUT
		|=> rdValid && rdData == $past(backupIout)) else $error("iout read wrong");
	chk_read_input: assert property (@(posedge clock) disable iff (!rst_b)
		readCall && accessOk && rdStatusCmd == SEL_INPUT
		|=> rdValid && rdData == $past(backupInput)) else $error("input read wrong");
	chk_read_comms: assert property (@(posedge clock) disable iff (!rst_b)
		readCall && accessOk && rdStatusCmd == SEL_COMMS
		|=> rdValid && rdData == $past(backupComms)) else $error("comms read wrong");
	chk_alert_follows: assert property (@(posedge clock) disable iff (!rst_b)
		(|(statusVout & ~backupVout) || |(statusIout & ~backupIout) ||
		|(statusInput & ~backupInput) || |(statusTemp & ~backupTemp) ||
		|(statusComms & ~backupComms)) |=> alert) else $error("alert missed unmasked status");
	chk_masked_quiet: assert property (@(posedge clock) disable iff (!rst_b)
		((statusVout & ~backupVout) | (statusIout & ~backupIout) |
		(statusInput & ~backupInput) | (statusTemp & ~backupTemp) |
		(statusComms & ~backupComms)) == ZERO_BYTE
		|=> !alert) else $error("masked status raised alert");
	chk_field_alert: assert property (@(posedge clock) disable iff (!rst_b)
		fieldAlert |=> alert) else $error("named field did not raise alert");
endmodule

// File: testbench/alert_mask_bank_bench.sv
`timescale 1ns/10ps
module alert_mask_bank_bench
	import amb_pkg::*;
;
	localparam logic [7:0] SEL [NUM_CAT] = '{SEL_VOUT, SEL_IOUT, SEL_INPUT, SEL_TEMP, SEL_COMMS};
	localparam logic [7:0] WM [NUM_CAT] = '{WMASK_VOUT, WMASK_IOUT, WMASK_INPUT, WMASK_TEMP,
		WMASK_COMMS};
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic nvmLoad = 1'b0;
	logic [7:0] nvm [NUM_CAT];
	logic [7:0] st [NUM_CAT];
	logic [7:0] bk [NUM_CAT];
	logic [7:0] phase, cmdCode, wrLowByte, wrHighByte, rdStatusCmd, rdData, statusOutVout;
	logic wordWrite, readCall, rdValid, badData, alert;
	logic [7:0] q [$];
	logic [15:0] lf = 16'hE1B2;
	int err_count = 0;
	int tests_run = 0;
	always #25 clock = ~clock;
	amb_host_model amb_host_model_i (.clock(clock), .phase(phase), .cmdCode(cmdCode),
		.wordWrite(wordWrite), .wrLowByte(wrLowByte), .wrHighByte(wrHighByte),
		.readCall(readCall), .rdStatusCmd(rdStatusCmd));
	amb_alert_mask_bank amb_alert_mask_bank_i (.clock(clock), .rst_b(rst_b),
		.nvmVout(nvm[0]), .nvmIout(nvm[1]), .nvmInput(nvm[2]), .nvmTemp(nvm[3]),
		.nvmComms(nvm[4]), .nvmLoad(nvmLoad), .phase(phase), .cmdCode(cmdCode),
		.wordWrite(wordWrite), .wrLowByte(wrLowByte), .wrHighByte(wrHighByte),
		.readCall(readCall), .rdStatusCmd(rdStatusCmd), .statusVout(st[0]),
		.statusIout(st[1]), .statusInput(st[2]), .statusTemp(st[3]), .statusComms(st[4]),
		.rdData(rdData), .rdValid(rdValid), .badData(badData), .backupVout(bk[0]),
		.backupIout(bk[1]), .backupInput(bk[2]), .backupTemp(bk[3]), .backupComms(bk[4]),
		.statusOutVout(statusOutVout), .alert(alert));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic rdx(input int c, input logic [7:0] e);
		q.push_back(e);
		amb_host_model_i.rd(SEL[c], PHASE_ALL, CMD_ALERT_MASK);
	endtask
	task automatic alertIs(input logic e);
		repeat (2) @(posedge clock);
		#1;
		chk({7'h00, alert}, {7'h00, e});
	endtask
	always @(posedge clock) begin
		#2;
		if (rdValid === 1'b1) begin
			if (q.size() == 0)
				chk(8'h01, 8'h00);
			else
				chk(rdData, q.pop_front());
		end
	end
	initial begin
		#200000;
		err_count++;
		results();
	end
	initial begin
		logic [7:0] v;
		for (int i = 0; i < NUM_CAT; i++) begin
			lf = nx(lf);
			nvm[i] = lf[7:0];
			st[i] = 8'h00;
		end
		repeat (10) @(posedge clock);
		#1 rst_b = 1'b1;
		for (int i = 0; i < NUM_CAT; i++)
			rdx(i, nvm[i] & WM[i]);
		for (int k = 0; k < 4; k++) begin
			lf = nx(lf);
			v = (k == 0) ? 8'h00 : (k == 1) ? lf[7:0] : 8'hFF;
			for (int i = 0; i < NUM_CAT; i++) begin
				amb_host_model_i.wr(SEL[i], v, PHASE_ALL, CMD_ALERT_MASK);
				chk(bk[i], v & WM[i]);
				chk({7'h00, badData}, 8'h00);
				rdx(i, v & WM[i]);
			end
		end
		amb_host_model_i.wr(SEL_IOUT, 8'h00, 8'h00, CMD_ALERT_MASK);
		chk({7'h00, badData}, 8'h01);
		amb_host_model_i.wr(8'h7F, 8'h00, PHASE_ALL, CMD_ALERT_MASK);
		chk({7'h00, badData}, 8'h01);
		amb_host_model_i.wr(SEL_IOUT, 8'h00, PHASE_ALL, 8'h1C);
		chk({7'h00, badData}, 8'h00);
		rdx(CAT_IOUT, WMASK_IOUT);
		amb_host_model_i.rd(SEL_TEMP, 8'h00, CMD_ALERT_MASK);
		chk({7'h00, badData}, 8'h01);
		amb_host_model_i.rd(8'h79, PHASE_ALL, CMD_ALERT_MASK);
		chk({7'h00, badData}, 8'h01);
		for (int i = 0; i < NUM_CAT; i++)
			st[i] = WM[i];
		alertIs(1'b0);
		chk(statusOutVout, WMASK_VOUT);
		for (int i = 0; i < NUM_CAT; i++) begin
			amb_host_model_i.wr(SEL[i], 8'h00, PHASE_ALL, CMD_ALERT_MASK);
			alertIs(1'b1);
			amb_host_model_i.wr(SEL[i], 8'hFF, PHASE_ALL, CMD_ALERT_MASK);
			alertIs(1'b0);
		end
		for (int i = 0; i < NUM_CAT; i++) begin
			lf = nx(lf);
			nvm[i] = lf[7:0];
		end
		nvmLoad = 1'b1;
		@(posedge clock);
		#1 nvmLoad = 1'b0;
		for (int i = 0; i < NUM_CAT; i++)
			rdx(i, nvm[i] & WM[i]);
		repeat (3) @(posedge clock);
		results();
	end
endmodule

// File: testbench/amb_host_model.sv
`timescale 1ns/10ps
module amb_host_model
	import amb_pkg::*;
(
	input wire logic clock,
	output logic [7:0] phase,
	output logic [7:0] cmdCode,
	output logic wordWrite,
	output logic [7:0] wrLowByte,
	output logic [7:0] wrHighByte,
	output logic readCall,
	output logic [7:0] rdStatusCmd
);
	initial begin
		phase = PHASE_ALL;
		cmdCode = CMD_ALERT_MASK;
		{wordWrite, readCall, wrLowByte, wrHighByte, rdStatusCmd} = '0;
	end
	// word write: low byte selects, high byte is the mask
	task automatic wr(input logic [7:0] sub, input logic [7:0] val, input logic [7:0] ph,
		input logic [7:0] cmd);
		@(posedge clock);
		#1;
		phase = ph;
		cmdCode = cmd;
		wrLowByte = sub;
		wrHighByte = val;
		wordWrite = 1'b1;
		@(posedge clock);
		#1;
		wordWrite = 1'b0;
		wrHighByte = ~val;
	endtask
	// process-call read of a one-byte block
	task automatic rd(input logic [7:0] sub, input logic [7:0] ph, input logic [7:0] cmd);
		@(posedge clock);
		#1;
		phase = ph;
		cmdCode = cmd;
		rdStatusCmd = sub;
		readCall = 1'b1;
		@(posedge clock);
		#1;
		readCall = 1'b0;
		rdStatusCmd = ~sub;
	endtask
endmodule
